// *** pkg/acr_pkg.sv ***
package acr_pkg;

  // ************************************************************
  // bus map
  // ************************************************************
  localparam logic [7:0] ACR_OFF_RESULT_LOW    = 8'h00;
  localparam logic [7:0] ACR_OFF_RESULT_HIGH   = 8'h04;
  localparam logic [7:0] ACR_OFF_MAIN_CONTROL  = 8'h08;
  localparam logic [7:0] ACR_OFF_SRC_CLK_SEL   = 8'h0C;
  localparam logic [7:0] ACR_OFF_REF_CONTROL   = 8'h10;
  localparam logic [7:0] ACR_OFF_BANDGAP       = 8'h14;
  localparam logic [7:0] ACR_OFF_PIN_SELECT    = 8'h18;
  localparam logic [7:0] ACR_OFF_INT_STATUS    = 8'h1C;
  localparam logic [7:0] ACR_OFF_INT_MASK      = 8'h20;

  // ************************************************************
  // field layout
  // ************************************************************
  localparam int ACR_BIT_START  = 7;
  localparam int ACR_BIT_BUSY   = 6;
  localparam int ACR_BIT_ENABLE = 5;
  localparam int ACR_BIT_FORMAT = 4;
  localparam int ACR_BIT_INT_DONE = 0;

  localparam logic [7:0] ACR_MAIN_WR_MASK   = 8'hBF;
  localparam logic [7:0] ACR_SRC_CLK_MASK   = 8'hF7;
  localparam logic [7:0] ACR_REF_CTRL_MASK  = 8'h9F;
  localparam logic [7:0] ACR_BANDGAP_MASK   = 8'h01;
  localparam logic [7:0] ACR_INT_MASK_BITS  = 8'h01;

  localparam logic [7:0]  ACR_RESET_BYTE    = 8'h00;
  localparam logic [11:0] ACR_RESET_PINS    = 12'h000;

  // ************************************************************
  // converter constants
  // ************************************************************
  localparam int ACR_RESULT_BITS = 12;
  localparam int ACR_NUM_CHANNELS = 12;
  localparam logic [4:0] ACR_CONV_TICKS = 5'h10;
  localparam logic [6:0] ACR_DIV_ONE    = 7'h01;

  // external source codes of the input signal select: 0000, 0100, 11xx
  function automatic logic acr_is_external(input logic [3:0] code);
    acr_is_external = (code == 4'h0) || (code == 4'h4) || (code[3:2] == 2'h3);
  endfunction

  // one-hot connect for a channel code; 11xx leaves the input floating
  function automatic logic [11:0] acr_channel_onehot(input logic [3:0] code);
    acr_channel_onehot = 12'h000;
    if (code[3:2] != 2'h3)
      acr_channel_onehot[code] = 1'b1;
  endfunction

endpackage

// *** logic/acr_clock_divider.sv ***
`timescale 1ns/100ps
module acr_clock_divider
  import acr_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       restart,
  input  wire logic [2:0] clock_select,
  output logic            tick
);

  logic [6:0] count_q;
  logic [6:0] mask;

  // ************************************************************
  // divide by two to the power of the select code
  // ************************************************************
  assign mask = 7'((ACR_DIV_ONE << clock_select) - ACR_DIV_ONE);
  assign tick = ((count_q & mask) == mask);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count_q <= 7'h00;
    else if (restart)
      count_q <= 7'h00;
    else
      count_q <= 7'(count_q + ACR_DIV_ONE);
  end

endmodule

// *** logic/acr_sequencer.sv ***
`timescale 1ns/100ps
module acr_sequencer
  import acr_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic enable,
  input  wire logic launch,
  input  wire logic tick,
  output logic      busy,
  output logic      done
);

  typedef enum logic {ACR_IDLE, ACR_CONVERT} acr_state_t;

  acr_state_t state_q;
  logic [4:0] ticks_q;

  assign busy = (state_q == ACR_CONVERT);
  assign done = busy && enable && !launch && tick && (ticks_q == 5'(ACR_CONV_TICKS - 5'h01));

  // ************************************************************
  // fixed length conversion, restart on relaunch
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= ACR_IDLE;
      ticks_q <= 5'h00;
    end
    else if (!enable)
    begin
      state_q <= ACR_IDLE;
      ticks_q <= 5'h00;
    end
    else if (launch)
    begin
      state_q <= ACR_CONVERT;
      ticks_q <= 5'h00;
    end
    else
    begin
      unique case (state_q)
        ACR_IDLE:
          ticks_q <= 5'h00;
        ACR_CONVERT:
          if (done)
            state_q <= ACR_IDLE;
          else if (tick)
            ticks_q <= 5'(ticks_q + 5'h01);
      endcase
    end
  end

endmodule

// *** logic/acr_top.sv ***
// What this block does
// - start bit written high then low launches
// - busy flag set at launch, cleared at end
// - converter enable off powers converter down
// - disabled converter leaves result registers unchanged
// - format zero: left justified result bytes
// - format one: right justified result bytes
// - unused result bit positions read zero
// - each conversion yields twelve result bits
// - channel code selects external input 0..11
// - channel codes 11xx leave input floating
// - internal source disconnects every external channel
// - analog pin loses its shared function
// - analog pin loses its pull-high resistor
// - clock select divides system clock by 2^n
// - input select routes external or internal source
`timescale 1ns/100ps
module acr_top
  import acr_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [11:0] conv_data,
  output logic             conv_power_on,
  output logic             conv_clock_tick,
  output logic             conv_sample_start,
  output logic      [11:0] ext_channel_connect,
  output logic             int_source_connect,
  output logic      [3:0]  int_source_code,
  output logic      [7:0]  ref_control,
  output logic             bandgap_enable,
  output logic      [11:0] pin_function_off,
  output logic      [11:0] pin_pullup_off,
  output logic             irq
);

  // ************************************************************
  // register state
  // ************************************************************
  logic [7:0]  result_low_q;
  logic [7:0]  result_high_q;
  logic [7:0]  main_control_q;
  logic [7:0]  src_clk_sel_q;
  logic [7:0]  ref_control_q;
  logic [7:0]  bandgap_q;
  logic [11:0] pin_select_q;
  logic [7:0]  int_status_q;
  logic [7:0]  int_mask_q;

  logic        wr_pending_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] hrdata_q;
  logic        launch_q;

  logic        addr_phase;
  logic        wr_now;
  logic [7:0]  wdata;
  logic        busy;
  logic        done;
  logic        tick;
  logic        enable;
  logic        format_right;
  logic [7:0]  main_control_rd;

  assign enable       = main_control_q[ACR_BIT_ENABLE];
  assign format_right = main_control_q[ACR_BIT_FORMAT];
  assign addr_phase   = hsel && hready && htrans[1];
  assign wr_now       = wr_pending_q;
  assign wdata        = hwdata[7:0];

  // ************************************************************
  // bus slave: zero wait state, always OKAY
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pending_q <= 1'b0;
      wr_addr_q    <= 8'h00;
    end
    else
    begin
      wr_pending_q <= addr_phase && hwrite;
      wr_addr_q    <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // busy covers launch, drops with enable
  always_comb
  begin
    main_control_rd = main_control_q;
    main_control_rd[ACR_BIT_BUSY] = enable && (busy || launch_q);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_q <= 32'h0000_0000;
    else if (addr_phase && !hwrite)
    begin
      unique case (haddr[7:0])
        ACR_OFF_RESULT_LOW:   hrdata_q <= {24'h000000, result_low_q};
        ACR_OFF_RESULT_HIGH:  hrdata_q <= {24'h000000, result_high_q};
        ACR_OFF_MAIN_CONTROL: hrdata_q <= {24'h000000, main_control_rd};
        ACR_OFF_SRC_CLK_SEL:  hrdata_q <= {24'h000000, src_clk_sel_q};
        ACR_OFF_REF_CONTROL:  hrdata_q <= {24'h000000, ref_control_q};
        ACR_OFF_BANDGAP:      hrdata_q <= {24'h000000, bandgap_q};
        ACR_OFF_PIN_SELECT:   hrdata_q <= {20'h00000, pin_select_q};
        ACR_OFF_INT_STATUS:   hrdata_q <= {24'h000000, int_status_q};
        ACR_OFF_INT_MASK:     hrdata_q <= {24'h000000, int_mask_q};
        default:              hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign hrdata = hrdata_q;

  // ************************************************************
  // main control and start sequence
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      main_control_q <= ACR_RESET_BYTE;
    else if (wr_now && (wr_addr_q == ACR_OFF_MAIN_CONTROL))
      main_control_q <= wdata & ACR_MAIN_WR_MASK;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      launch_q <= 1'b0;
    else
      launch_q <= wr_now && (wr_addr_q == ACR_OFF_MAIN_CONTROL) && main_control_q[ACR_BIT_START]
                  && !wdata[ACR_BIT_START] && wdata[ACR_BIT_ENABLE];
  end

  // ************************************************************
  // other control registers
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      src_clk_sel_q <= ACR_RESET_BYTE;
    else if (wr_now && (wr_addr_q == ACR_OFF_SRC_CLK_SEL))
      src_clk_sel_q <= wdata & ACR_SRC_CLK_MASK;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ref_control_q <= ACR_RESET_BYTE;
    else if (wr_now && (wr_addr_q == ACR_OFF_REF_CONTROL))
      ref_control_q <= wdata & ACR_REF_CTRL_MASK;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      bandgap_q <= ACR_RESET_BYTE;
    else if (wr_now && (wr_addr_q == ACR_OFF_BANDGAP))
      bandgap_q <= wdata & ACR_BANDGAP_MASK;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pin_select_q <= ACR_RESET_PINS;
    else if (wr_now && (wr_addr_q == ACR_OFF_PIN_SELECT))
      pin_select_q <= hwdata[11:0];
  end

  // ************************************************************
  // conversion clock and sequencer
  // ************************************************************
  // power of two divider, restarted per launch
  acr_clock_divider u_divider (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .restart      (launch_q),
    .clock_select (src_clk_sel_q[2:0]),
    .tick         (tick)
  );

  acr_sequencer u_sequencer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .enable  (enable),
    .launch  (launch_q),
    .tick    (tick),
    .busy    (busy),
    .done    (done)
  );

  // ************************************************************
  // result registers
  // ************************************************************
  // only a finished conversion writes results
  // both bytes update as busy clears
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      result_low_q  <= ACR_RESET_BYTE;
      result_high_q <= ACR_RESET_BYTE;
    end
    else if (done)
    begin
      if (format_right)
      begin
        result_high_q <= {4'h0, conv_data[11:8]};
        result_low_q  <= conv_data[7:0];
      end
      else
      begin
        result_high_q <= conv_data[11:4];
        result_low_q  <= {conv_data[3:0], 4'h0};
      end
    end
  end

  // ************************************************************
  // interrupt: sticky done, write one to clear
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      int_status_q <= ACR_RESET_BYTE;
    else
    begin
      if (wr_now && (wr_addr_q == ACR_OFF_INT_STATUS))
        int_status_q <= int_status_q & ~(wdata & ACR_INT_MASK_BITS);
      if (done)
        int_status_q[ACR_BIT_INT_DONE] <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      int_mask_q <= ACR_RESET_BYTE;
    else if (wr_now && (wr_addr_q == ACR_OFF_INT_MASK))
      int_mask_q <= wdata & ACR_INT_MASK_BITS;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= |(int_status_q & int_mask_q);
  end

  // ************************************************************
  // converter core controls
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      conv_power_on     <= 1'b0;
      conv_clock_tick   <= 1'b0;
      conv_sample_start <= 1'b0;
    end
    else
    begin
      conv_power_on     <= enable;
      conv_clock_tick   <= busy && tick;
      conv_sample_start <= launch_q;
    end
  end

  // ************************************************************
  // input routing
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_channel_connect <= 12'h000;
      int_source_connect  <= 1'b0;
      int_source_code     <= 4'h0;
    end
    else
    begin
      int_source_code <= src_clk_sel_q[7:4];
      // external codes route the channel mux
      if (acr_is_external(src_clk_sel_q[7:4]))
      begin
        ext_channel_connect <= acr_channel_onehot(main_control_q[3:0]);
        int_source_connect  <= 1'b0;
      end
      else
      begin
        ext_channel_connect <= 12'h000;
        int_source_connect  <= 1'b1;
      end
    end
  end

  // ************************************************************
  // pin sharing and reference outputs
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_function_off <= ACR_RESET_PINS;
      pin_pullup_off   <= ACR_RESET_PINS;
      ref_control      <= ACR_RESET_BYTE;
      bandgap_enable   <= 1'b0;
    end
    else
    begin
      // analog pin drops its shared function
      pin_function_off <= pin_select_q;
      pin_pullup_off   <= pin_select_q;
      ref_control      <= ref_control_q;
      bandgap_enable   <= bandgap_q[0];
    end
  end

endmodule

// *** test/acr_analog_model.sv ***
`timescale 1ns/100ps
module acr_analog_model
(
  input  wire logic        hclk,
  input  wire logic        conv_power_on,
  input  wire logic [11:0] ext_channel_connect,
  input  wire logic        int_source_connect,
  input  wire logic [3:0]  int_source_code,
  output logic      [11:0] conv_data
);
  logic [11:0] float_q = 12'h000;
  int          i;

  // nothing connected: the input floats, so the level wanders each cycle
  always @(posedge hclk)
  begin
    float_q <= ~float_q ^ 12'h5A5;
  end

  always_comb
  begin
    conv_data = float_q;
    if (int_source_connect)
      conv_data = {8'hC3, int_source_code};
    else
      for (i = 0; i < 12; i++)
        if (ext_channel_connect[i])
          conv_data = {8'h5A, i[3:0]};
    if (!conv_power_on)
      conv_data = float_q;
  end
endmodule

// *** test/acr_top_props.sv ***
`timescale 1ns/100ps
module acr_top_props
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        conv_power_on,
  input wire logic        conv_clock_tick,
  input wire logic        conv_sample_start,
  input wire logic [11:0] ext_channel_connect,
  input wire logic        int_source_connect,
  input wire logic [3:0]  int_source_code,
  input wire logic [11:0] pin_function_off,
  input wire logic [11:0] pin_pullup_off
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ticks seen since the last sample start; a tick in the start cycle belongs to the run before
  logic [4:0] tick_cnt_q;
  logic [4:0] tick_cnt_d;

  always_comb
  begin
    tick_cnt_d = conv_sample_start ? 5'h00 : 5'(tick_cnt_q + {4'h0, conv_clock_tick});
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tick_cnt_q <= 5'h00;
    else
      tick_cnt_q <= tick_cnt_d;
  end

  sequence s_off3;
    !conv_power_on [*3];
  endsequence

  property p_bus_okay; hreadyout && !hresp; endproperty
  property p_onehot; $onehot0(ext_channel_connect); endproperty
  property p_int_off; int_source_connect |-> ext_channel_connect == 12'h000; endproperty
  property p_int_code;
    int_source_connect == !(int_source_code == 4'h0 || int_source_code == 4'h4 || int_source_code[3:2] == 2'h3);
  endproperty
  property p_pins; pin_function_off == pin_pullup_off; endproperty
  property p_start_enabled; conv_sample_start |-> conv_power_on; endproperty
  property p_start_pulse; conv_sample_start |=> !conv_sample_start; endproperty
  property p_tick_count; tick_cnt_q <= 5'h10; endproperty
  property p_off_quiet; s_off3 |-> !conv_clock_tick; endproperty

  a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready okay");
  a_onehot: assert property (p_onehot) else $error("more than one channel connected");
  a_int_off: assert property (p_int_off) else $error("external channel left on with internal source");
  a_int_code: assert property (p_int_code) else $error("internal connect disagrees with select code");
  a_pins: assert property (p_pins) else $error("pin function and pull-high disagree");
  a_start_enabled: assert property (p_start_enabled) else $error("sample start while powered off");
  a_start_pulse: assert property (p_start_pulse) else $error("sample start longer than a cycle");
  a_tick_count: assert property (p_tick_count) else $error("more than sixteen ticks per conversion");
  a_off_quiet: assert property (p_off_quiet) else $error("conversion clock runs while powered off");
endmodule

bind acr_top acr_top_props u_props (
  .hclk                (hclk),
  .hresetn             (hresetn),
  .hreadyout           (hreadyout),
  .hresp               (hresp),
  .conv_power_on       (conv_power_on),
  .conv_clock_tick     (conv_clock_tick),
  .conv_sample_start   (conv_sample_start),
  .ext_channel_connect (ext_channel_connect),
  .int_source_connect  (int_source_connect),
  .int_source_code     (int_source_code),
  .pin_function_off    (pin_function_off),
  .pin_pullup_off      (pin_pullup_off)
);

// *** test/test_adc_control_result_regs.sv ***
`timescale 1ns/100ps
module test_adc_control_result_regs;
  import acr_pkg::*;
  logic        hclk, hresetn, hwrite, hreadyout, hresp, irq, bandgap_enable;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [11:0] conv_data, ext_channel_connect, pin_function_off, pin_pullup_off;
  logic        conv_power_on, conv_clock_tick, conv_sample_start, int_source_connect;
  logic [3:0]  int_source_code;
  logic [7:0]  ref_control;
  logic [11:0] d;
  logic [3:0]  ins;
  int          mismatches = 0, n_tests = 0, cyc = 0, i;
  logic [7:0]  ta [6] = '{8'h0C, 8'h10, 8'h14, 8'h24, 8'h00, 8'h08};
  logic [7:0]  te [6] = '{8'hF7, 8'h9F, 8'h01, 8'h00, 8'h00, 8'h00};

  acr_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .conv_data(conv_data), .conv_power_on(conv_power_on), .conv_clock_tick(conv_clock_tick),
    .conv_sample_start(conv_sample_start), .ext_channel_connect(ext_channel_connect),
    .int_source_connect(int_source_connect), .int_source_code(int_source_code), .ref_control(ref_control),
    .bandgap_enable(bandgap_enable), .pin_function_off(pin_function_off), .pin_pullup_off(pin_pullup_off), .irq(irq));
  acr_analog_model u_model (.hclk(hclk), .conv_power_on(conv_power_on), .ext_channel_connect(ext_channel_connect),
    .int_source_connect(int_source_connect), .int_source_code(int_source_code), .conv_data(conv_data));

  // ************************************************************
  // bus tasks
  // ************************************************************
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    xfer(a, 1'h1, wd);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'h0, 32'h00000000);
    chk(rd, exp);
  endtask

  // launch, poll busy, check the length against the clock select
  task automatic convert(input logic [7:0] main, input logic [2:0] sel);
    int t0;
    wr(8'h08, {24'h000000, main | 8'h80});
    wr(8'h08, {24'h000000, main});
    t0 = cyc;
    rchk(8'h08, {24'h000000, main | 8'h40});
    do xfer(8'h08, 1'h0, 32'h00000000); while (rd[6] === 1'h1 && cyc - t0 < 5000);
    chk(32'((cyc - t0 >= (16 << sel)) && (cyc - t0 <= (16 << sel) + 6)), 32'h1);
  endtask

  task automatic results;
    $display("mismatches %0d tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    hclk = 1'h0;
    forever #20 hclk = ~hclk;
  end

  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      mismatches++;
      results();
    end
  end

  // ************************************************************
  // tests
  // ************************************************************
  initial
  begin
    hresetn = 1'h0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'h0;
    hwdata = 32'h00000000;
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    for (i = 0; i < 10; i++) rchk(8'(i * 4), 32'h0);
    for (i = 0; i < 6; i++)
    begin
      wr(ta[i], (ta[i] == 8'h08) ? 32'h40 : 32'hFF);
      rchk(ta[i], {24'h0, te[i]});
    end
    chk({23'h0, bandgap_enable, ref_control}, 32'h19F);
    wr(8'h20, 32'h1);
    for (i = 0; i < 12; i++)
    begin
      ins = (i < 4) ? 4'h0 : ((i < 8) ? 4'h4 : 4'hC);
      // external source code for channel work
      wr(8'h0C, {24'h0, ins, 1'h0, 3'(i)});
      convert({3'h1, 1'(i), 4'(i)}, 3'(i));
      chk({20'h0, ext_channel_connect}, 32'h1 << i);
      d = {8'h5A, 4'(i)};
      // results only read once busy has cleared
      rchk(8'h04, (i % 2) ? {28'h0, d[11:8]} : {24'h0, d[11:4]});
      rchk(8'h00, (i % 2) ? {24'h0, d[7:0]} : {24'h0, d[3:0], 4'h0});
      chk({31'h0, irq}, 32'h1);
      wr(8'h1C, 32'h1);
      rchk(8'h1C, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    for (i = 0; i < 16; i++)
    begin
      wr(8'h0C, {24'h0, 4'(i), 4'h0});
      rchk(8'h0C, {24'h0, 4'(i), 4'h0});
      chk({31'h0, int_source_connect}, 32'(!(i == 0 || i == 4 || i >= 12)));
    end
    wr(8'h0C, 32'h10);
    convert(8'h25, 3'h0);
    chk({15'h0, int_source_code, ext_channel_connect, int_source_connect}, 32'h2001);
    rchk(8'h04, 32'hC3);
    rchk(8'h00, 32'h10);
    wr(8'h1C, 32'h1);
    wr(8'h0C, 32'h0);
    wr(8'h08, 32'h2C);
    rchk(8'h08, 32'h2C);
    chk({20'h0, ext_channel_connect}, 32'h0);
    wr(8'h08, 32'h85);
    wr(8'h08, 32'h05);
    rchk(8'h08, 32'h05);
    chk({31'h0, conv_power_on}, 32'h0);
    wr(8'h0C, 32'h07);
    wr(8'h08, 32'hA5);
    wr(8'h08, 32'h25);
    repeat (20) @(posedge hclk);
    wr(8'h08, 32'h05);
    rchk(8'h08, 32'h05);
    rchk(8'h04, 32'hC3);
    rchk(8'h00, 32'h10);
    rchk(8'h1C, 32'h0);
    wr(8'h0C, 32'h03);
    wr(8'h08, 32'hA5);
    wr(8'h08, 32'h25);
    repeat (60) @(posedge hclk);
    convert(8'h25, 3'h3);
    rchk(8'h04, 32'h5A);
    wr(8'h1C, 32'h1);
    wr(8'h18, 32'hA5C);
    rchk(8'h18, 32'hA5C);
    chk({8'h0, pin_function_off, pin_pullup_off}, 32'hA5CA5C);
    wr(8'h20, 32'h0);
    wr(8'h0C, 32'h0);
    convert(8'h25, 3'h0);
    rchk(8'h1C, 32'h1);
    chk({31'h0, irq}, 32'h0);
    results();
  end
endmodule
